// File: core/mhc_pkg.sv
/*
  Package of the maintenance hours counter: register map, field widths,
  reset values and timing constants.
  Assumes a 100 MHz system clock and a 32-bit classic Wishbone master.
*/
package mhc_pkg;

  // Clock and hour time base
  localparam longint unsigned CLK_HZ = 100000000;
  localparam longint unsigned HOUR_S = 3600;
  localparam longint unsigned HOUR_CYCLES = CLK_HZ * HOUR_S;

  // Value ranges
  localparam int MI_W = 14;
  localparam int OT_W = 17;
  localparam logic [MI_W-1:0] MI_MAX = 14'h270f;
  localparam logic [OT_W-1:0] OT_MAX = 17'h1869f;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_INTERVAL = 4'h4;
  localparam logic [3:0] REG_OPTIME = 4'h8;
  localparam logic [3:0] REG_TOGO = 4'hc;

  // Control register bit positions
  localparam int CTRL_CLR_EN_BIT = 0;
  localparam int CTRL_Q_IND_BIT = 1;
  localparam int CTRL_EXT_MI_BIT = 2;
  localparam int CTRL_START_BIT = 3;
  localparam int CTRL_Q_BIT = 8;

  // Reset values
  localparam logic [MI_W-1:0] MI_RST = 14'h0064;
  localparam logic [OT_W-1:0] OT_RST = 17'h00000;

  // Control-program inputs
  typedef struct packed {
    logic monitor;
    logic clear;
    logic clear_all;
  } mhc_ctl_t;

  // Stored counter state
  typedef struct packed {
    logic [MI_W-1:0] interval;
    logic [OT_W-1:0] optime;
    logic [MI_W-1:0] togo;
  } mhc_cnt_t;

endpackage : mhc_pkg

// File: core/mhc_hour_tick.sv
/*
  Hour time base: one-cycle enable pulse every CYCLES clocks while run is high.
  Assumes a single clock domain and synchronous active-low reset.
*/
`timescale 1ns/1ns
module mhc_hour_tick #(
  parameter longint unsigned CYCLES = mhc_pkg::HOUR_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic run,
  output logic tick
);

  logic [39:0] count;
  logic [39:0] next_count;
  logic next_tick;

  always_comb begin
    next_count = count;
    next_tick = 1'b0;
    if (run) begin
      if (count >= 40'(CYCLES - 1)) begin
        next_count = 40'h0;
        next_tick = 1'b1;
      end else begin
        next_count = count + 40'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      count <= 40'h0;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

endmodule : mhc_hour_tick

// File: core/mhc_counter.sv
/*
  Maintenance hours counter with a classic Wishbone register slave.
  Assumes the control program drives monitor, clear and clear_all from
  outside this clock domain, and that storage is kept powered so its
  contents survive loss of the rest of the supply.
*/
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ns
module mhc_counter #(
  parameter longint unsigned HOUR_CYCLES = mhc_pkg::HOUR_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic monitor_in,
  input wire logic clear_in,
  input wire logic clear_all_in,
  input wire logic [mhc_pkg::MI_W-1:0] ext_interval,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic switch_out
);

  // Three-stage synchronisers for the control-program inputs
  mhc_pkg::mhc_ctl_t s1, s2, s3;
  mhc_pkg::mhc_ctl_t in_now;
  mhc_pkg::mhc_ctl_t in_prev;
  mhc_pkg::mhc_ctl_t next_in_prev;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= {monitor_in, clear_in, clear_all_in};
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts only once stages two and three agree
  always_comb begin
    next_in_prev = in_prev;
    if (s2.monitor == s3.monitor) next_in_prev.monitor = s3.monitor;
    if (s2.clear == s3.clear) next_in_prev.clear = s3.clear;
    if (s2.clear_all == s3.clear_all) next_in_prev.clear_all = s3.clear_all;
    in_now = next_in_prev;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) in_prev <= '0;
    else in_prev <= next_in_prev;
  end

  logic clr_rise;
  logic clr_all_rise;
  assign clr_rise = in_now.clear & ~in_prev.clear;
  assign clr_all_rise = in_now.clear_all & ~in_prev.clear_all;

  // Hour time base runs only while monitored input is high
  logic hour_tick;

  mhc_hour_tick #(
    .CYCLES(HOUR_CYCLES)
  ) u_tick (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .run(in_prev.monitor),
    .tick(hour_tick)
  );

  // Control register and retained counters
  logic clr_en_opt;
  logic q_indep;
  logic ext_mi_sel;
  logic next_clr_en_opt, next_q_indep, next_ext_mi_sel;
  mhc_pkg::mhc_cnt_t cnt;
  mhc_pkg::mhc_cnt_t next_cnt;
  logic next_switch;
  logic [mhc_pkg::MI_W-1:0] mi_live;
  logic [mhc_pkg::MI_W-1:0] mi_clip;
  logic wb_req;
  logic wb_wr;
  logic start_req;
  logic [31:0] wdat;
  logic [mhc_pkg::OT_W-1:0] ot_mod;
  logic [mhc_pkg::MI_W-1:0] start_togo;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;
  assign wdat = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & wb_dat_i;

  // Live interval from another block or the stored constant, clipped to range
  assign mi_live = ext_mi_sel ? ext_interval : cnt.interval;
  assign mi_clip = (mi_live > mhc_pkg::MI_MAX) ? mhc_pkg::MI_MAX : mi_live;

  // Start value: interval minus remainder of operating time
  always_comb begin
    ot_mod = '0;
    start_togo = '0;
    if (mi_clip != '0) begin
      ot_mod = cnt.optime % {3'h0, mi_clip};
      start_togo = mi_clip - ot_mod[mhc_pkg::MI_W-1:0];
    end
  end

  assign start_req = wb_wr & (wb_adr_i == mhc_pkg::REG_CTRL) & wb_sel_i[0] & wb_dat_i[mhc_pkg::CTRL_START_BIT];

  always_comb begin
    next_clr_en_opt = clr_en_opt;
    next_q_indep = q_indep;
    next_ext_mi_sel = ext_mi_sel;
    next_cnt = cnt;
    next_switch = switch_out;
    // Counting first, so clear events below take priority over a tick
    // Tick lags the run flag a cycle; only monitored time makes one
    if (hour_tick) begin
      if (cnt.optime < mhc_pkg::OT_MAX) next_cnt.optime = cnt.optime + 17'h1;
      if (cnt.togo != '0) next_cnt.togo = cnt.togo - 14'h1;
    end
    if (next_cnt.togo == '0) next_switch = 1'b1;
    if (!in_prev.monitor && clr_en_opt && !q_indep) next_switch = 1'b0;
    if (clr_rise) begin
      next_cnt.togo = mi_clip;
      next_switch = 1'b0;
    end
    if (clr_all_rise) begin
      next_cnt.togo = mi_clip;
      next_cnt.optime = '0;
      next_switch = 1'b0;
    end
    if (wb_wr) begin
      unique case (wb_adr_i)
        mhc_pkg::REG_CTRL: begin
          if (wb_sel_i[0]) begin
            next_clr_en_opt = wb_dat_i[mhc_pkg::CTRL_CLR_EN_BIT];
            next_q_indep = wb_dat_i[mhc_pkg::CTRL_Q_IND_BIT];
            next_ext_mi_sel = wb_dat_i[mhc_pkg::CTRL_EXT_MI_BIT];
          end
        end
        mhc_pkg::REG_INTERVAL: begin
          next_cnt.interval = (wdat[mhc_pkg::MI_W-1:0] > mhc_pkg::MI_MAX) ? mhc_pkg::MI_MAX
                              : wdat[mhc_pkg::MI_W-1:0];
        end
        mhc_pkg::REG_OPTIME: begin
          next_cnt.optime = (wdat[mhc_pkg::OT_W-1:0] > mhc_pkg::OT_MAX) ? mhc_pkg::OT_MAX
                            : wdat[mhc_pkg::OT_W-1:0];
        end
        default: begin
        end
      endcase
    end
    if (start_req) begin
      next_cnt.togo = start_togo;
      next_switch = (start_togo == '0);
    end
  end

  // Only synchronous reset touches the counters; power-fail retention is the
  // job of the storage supply, so rstn is expected only at first power-up
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      clr_en_opt <= 1'b0;
      q_indep <= 1'b0;
      ext_mi_sel <= 1'b0;
      cnt.interval <= mhc_pkg::MI_RST;
      cnt.optime <= mhc_pkg::OT_RST;
      cnt.togo <= mhc_pkg::MI_RST;
      switch_out <= 1'b0;
    end else begin
      clr_en_opt <= next_clr_en_opt;
      q_indep <= next_q_indep;
      ext_mi_sel <= next_ext_mi_sel;
      cnt <= next_cnt;
      switch_out <= next_switch;
    end
  end

  // Wishbone answer: ack one cycle after the request, unmapped reads zero
  logic [31:0] next_dat;
  logic next_ack;

  always_comb begin
    next_ack = wb_req;
    next_dat = 32'h0;
    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        mhc_pkg::REG_CTRL: begin
          next_dat[mhc_pkg::CTRL_CLR_EN_BIT] = clr_en_opt;
          next_dat[mhc_pkg::CTRL_Q_IND_BIT] = q_indep;
          next_dat[mhc_pkg::CTRL_EXT_MI_BIT] = ext_mi_sel;
          next_dat[mhc_pkg::CTRL_Q_BIT] = switch_out;
        end
        mhc_pkg::REG_INTERVAL: next_dat[mhc_pkg::MI_W-1:0] = mi_clip;
        mhc_pkg::REG_OPTIME: next_dat[mhc_pkg::OT_W-1:0] = cnt.optime;
        mhc_pkg::REG_TOGO: next_dat[mhc_pkg::MI_W-1:0] = cnt.togo;
        default: next_dat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // Checks
  AST_OT_SATURATES: assert property (@(posedge ref_clk) disable iff (!rstn)
    cnt.optime == mhc_pkg::OT_MAX && !clr_all_rise && !wb_wr |=> cnt.optime == mhc_pkg::OT_MAX)
    else $error("operating time left its ceiling");
  AST_FROZEN_WHEN_LOW: assert property (@(posedge ref_clk) disable iff (!rstn)
    !in_prev.monitor && !hour_tick && !clr_rise && !clr_all_rise && !wb_wr
    |=> $stable(cnt.optime) && $stable(cnt.togo))
    else $error("counters moved while monitor low");
  AST_Q_AT_ZERO: assert property (@(posedge ref_clk) disable iff (!rstn)
    cnt.togo == '0 && !clr_rise && !clr_all_rise && !wb_wr && (in_prev.monitor || !clr_en_opt || q_indep)
    |=> switch_out)
    else $error("output not set at zero time-to-go");
  AST_CLEAR: assert property (@(posedge ref_clk) disable iff (!rstn)
    clr_rise && !clr_all_rise && !start_req && !wb_wr
    |=> !switch_out && cnt.togo == $past(mi_clip) && cnt.optime >= $past(cnt.optime))
    else $error("clear did not reload");
  AST_CLEAR_ALL: assert property (@(posedge ref_clk) disable iff (!rstn)
    clr_all_rise && !start_req && !wb_wr |=> !switch_out && cnt.optime == '0 && cnt.togo == $past(mi_clip))
    else $error("clear-all did not zero");
  AST_MON_LOW_CLEARS: assert property (@(posedge ref_clk) disable iff (!rstn)
    !in_prev.monitor && clr_en_opt && !q_indep && !start_req |=> !switch_out)
    else $error("monitor low did not drop output");
  AST_Q_INDEPENDENT: assert property (@(posedge ref_clk) disable iff (!rstn)
    switch_out && q_indep && !clr_rise && !clr_all_rise && !wb_wr |=> switch_out)
    else $error("output dropped while independent");
  AST_TICK_COUNTS: assert property (@(posedge ref_clk) disable iff (!rstn)
    hour_tick && cnt.optime < mhc_pkg::OT_MAX && !clr_all_rise && !wb_wr
    |=> cnt.optime == $past(cnt.optime) + 17'h1)
    else $error("operating time missed a tick");
  AST_START_VALUE: assert property (@(posedge ref_clk) disable iff (!rstn)
    start_req |=> cnt.togo == $past(start_togo))
    else $error("start value not loaded");
  AST_WB_ACK: assert property (@(posedge ref_clk) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  // Range and time base
  AST_INTERVAL_RANGE: assert property (@(posedge ref_clk) disable iff (!rstn)
    cnt.interval <= mhc_pkg::MI_MAX && mi_clip <= mhc_pkg::MI_MAX)
    else $error("interval out of range");

  AST_OT_RANGE: assert property (@(posedge ref_clk) disable iff (!rstn)
    cnt.optime <= mhc_pkg::OT_MAX)
    else $error("operating time out of range");

  AST_TICK_FROM_RUN: assert property (@(posedge ref_clk) disable iff (!rstn)
    hour_tick |-> $past(in_prev.monitor))
    else $error("hour tick without monitored time");

  AST_TOGO_STEP: assert property (@(posedge ref_clk) disable iff (!rstn)
    hour_tick && cnt.togo != '0 && !clr_rise && !clr_all_rise && !wb_wr
    |=> cnt.togo == $past(cnt.togo) - 14'h1)
    else $error("time-to-go missed a tick");

  AST_TOGO_FLOOR: assert property (@(posedge ref_clk) disable iff (!rstn)
    hour_tick && cnt.togo == '0 && !clr_rise && !clr_all_rise && !wb_wr |=> cnt.togo == '0)
    else $error("time-to-go wrapped below zero");

  AST_CLEAR_KEEPS_OT: assert property (@(posedge ref_clk) disable iff (!rstn)
    clr_rise && !clr_all_rise && !hour_tick && !wb_wr |=> $stable(cnt.optime))
    else $error("clear touched operating time");

  // Input edges
  AST_CLEAR_EDGE: assert property (@(posedge ref_clk) disable iff (!rstn)
    clr_rise |-> !$past(in_now.clear))
    else $error("clear acted without a rising edge");

  AST_CLEAR_ALL_EDGE: assert property (@(posedge ref_clk) disable iff (!rstn)
    clr_all_rise |-> !$past(in_now.clear_all))
    else $error("clear-all acted without a rising edge");

  // Interval source and start value
  AST_EXT_INTERVAL: assert property (@(posedge ref_clk) disable iff (!rstn)
    ext_mi_sel && clr_rise && !clr_all_rise && !wb_wr
    |=> cnt.togo == (($past(ext_interval) > mhc_pkg::MI_MAX) ? mhc_pkg::MI_MAX : $past(ext_interval)))
    else $error("clear ignored the live interval");

  AST_PRESET: assert property (@(posedge ref_clk) disable iff (!rstn)
    wb_wr && wb_adr_i == mhc_pkg::REG_OPTIME && wb_sel_i == 4'hf && wb_dat_i <= 32'(mhc_pkg::OT_MAX)
    |=> cnt.optime == $past(wb_dat_i[mhc_pkg::OT_W-1:0]))
    else $error("operating time preset lost");

  AST_START_ARITH: assert property (@(posedge ref_clk) disable iff (!rstn)
    start_req && mi_clip != '0
    |-> 17'(start_togo) + ot_mod == {3'h0, mi_clip} && ot_mod < {3'h0, mi_clip})
    else $error("start value does not add up");

  // Register bus
  AST_WB_IDLE_DATA: assert property (@(posedge ref_clk) disable iff (!rstn)
    !wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data while not acking");

  AST_WB_ACK_REQ: assert property (@(posedge ref_clk) disable iff (!rstn)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");

  AST_WB_RD_Q: assert property (@(posedge ref_clk) disable iff (!rstn)
    wb_req && !wb_we_i && wb_adr_i == mhc_pkg::REG_CTRL
    |=> wb_dat_o[mhc_pkg::CTRL_Q_BIT] == $past(switch_out))
    else $error("control read lost the output state");

  // Scenarios
  COV_EXPIRE: cover property (@(posedge ref_clk) disable iff (!rstn) !switch_out ##1 switch_out);
  COV_CLEAR: cover property (@(posedge ref_clk) disable iff (!rstn) switch_out && clr_rise);
  COV_CLEAR_ALL: cover property (@(posedge ref_clk) disable iff (!rstn) clr_all_rise);
  COV_SATURATE: cover property (@(posedge ref_clk) disable iff (!rstn) cnt.optime == mhc_pkg::OT_MAX);
  COV_START: cover property (@(posedge ref_clk) disable iff (!rstn) start_req);

endmodule : mhc_counter

// File: verif/mhc_ctl_model.sv
/*
  Control-program model: drives monitor, clear and clear-all pins.
  Assumes the bench sets the wanted levels just after a clock edge.
*/
`timescale 1ns/1ns
module mhc_ctl_model (
  input wire logic ref_clk,
  input wire mhc_pkg::mhc_ctl_t want,
  output logic monitor_in,
  output logic clear_in,
  output logic clear_all_in
);
  // Pins follow the program's outputs one scan later
  always @(posedge ref_clk) begin
    monitor_in <= want.monitor;
    clear_in <= want.clear;
    clear_all_in <= want.clear_all;
  end
endmodule : mhc_ctl_model

// File: verif/testbench.sv
/*
  Self-checking bench of the maintenance hours counter.
  Assumes a ten-cycle hour and a one-cycle Wishbone answer.
*/
`timescale 1ns/1ns
module testbench;
  localparam int HC = 10;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [13:0] ext = 14'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic switch_out;
  logic monitor_in;
  logic clear_in;
  logic clear_all_in;
  mhc_pkg::mhc_ctl_t want = '0;
  int n_errors = 0;
  int checked = 0;
  int mi = 100;
  int ot = 0;
  int tg = 100;
  int k;
  logic sw = 1'b0;
  logic [31:0] cfg = 32'h0;
  logic [31:0] r = 32'h39c9;
  logic [31:0] q;

  always #5 ref_clk = ~ref_clk;

  mhc_ctl_model u_ctl (.ref_clk(ref_clk), .want(want), .monitor_in(monitor_in), .clear_in(clear_in),
    .clear_all_in(clear_all_in));
  mhc_counter #(.HOUR_CYCLES(HC)) u_dut (.ref_clk(ref_clk), .rstn(rstn), .monitor_in(monitor_in),
    .clear_in(clear_in), .clear_all_in(clear_all_in), .ext_interval(ext), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .switch_out(switch_out));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic int st(input int m, input int o);
    return m - (o % m);
  endfunction : st

  task automatic conclude();
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wt

  // One classic cycle; called and left just after a rising edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] o);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1);
    o = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    chk("ack", n, 2);
    wt(1);
  endtask : wb

  task automatic rc(input string nm, input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] o;
    wb(1'b0, a, 32'h0, o);
    chk(nm, o & m, e);
  endtask : rc

  task automatic cf(input logic [31:0] v);
    wb(1'b1, 4'h0, v, q);
    cfg = v;
  endtask : cf

  task automatic mon(input int h);
    want.monitor <= 1'b1;
    wt(h * HC);
    want.monitor <= 1'b0;
    ot = (ot + h > 99999) ? 99999 : ot + h;
    tg = (tg > h) ? tg - h : 0;
    if (tg == 0)
      sw = 1'b1;
    wt(8);
    if (cfg[0] && !cfg[1])
      sw = 1'b0;
    chk("switch", switch_out, sw);
    rc("optime", 4'h8, 32'h1ffff, ot);
    rc("togo", 4'hc, 32'h3fff, tg);
  endtask : mon

  task automatic pulse(input logic all);
    if (all)
      want.clear_all <= 1'b1;
    else
      want.clear <= 1'b1;
    wt(8);
    want <= '0;
    wt(8);
    sw = (mi == 0);
    tg = mi;
    if (all)
      ot = 0;
    chk("switch", switch_out, sw);
    rc("togo", 4'hc, 32'h3fff, tg);
    rc("optime", 4'h8, 32'h1ffff, ot);
  endtask : pulse

  initial begin
    wt(20000);
    n_errors++;
    conclude();
  end

  initial begin
    wt(4);
    rstn <= 1'b1;
    wt(4);
    rc("ctrl", 4'h0, 32'h100, 0);
    rc("interval", 4'h4, 32'hffffffff, 100);
    rc("optime", 4'h8, 32'hffffffff, 0);
    rc("unmapped", 4'h2, 32'hffffffff, 0);
    wb(1'b1, 4'hc, 32'h5, q);
    rc("togo", 4'hc, 32'hffffffff, 100);
    $display("test reset done");
    r = lfsr(r);
    mi = r % 40 + 2;
    r = lfsr(r);
    ot = r % 100000;
    wb(1'b1, 4'h4, mi, q);
    wb(1'b1, 4'h8, ot, q);
    cf(32'h8);
    tg = st(mi, ot);
    rc("togo", 4'hc, 32'h3fff, tg);
    rc("optime", 4'h8, 32'h1ffff, ot);
    $display("test start done");
    for (int i = 0; i < 3; i++) begin
      r = lfsr(r);
      k = r % 5 + 1;
      mon(k);
      wt(3 * HC);
      rc("frozen", 4'h8, 32'h1ffff, ot);
    end
    mon(tg + 1);
    rc("ctrl", 4'h0, 32'h100, 32'h100);
    want.clear <= 1'b1;
    wt(8);
    sw = 1'b0;
    tg = mi;
    mon(2);
    want.clear <= 1'b0;
    wt(8);
    $display("test count and held clear done");
    cf(32'h1);
    pulse(1'b0);
    mon(mi);
    cf(32'h3);
    pulse(1'b0);
    mon(mi);
    pulse(1'b1);
    $display("test output modes done");
    r = lfsr(r);
    ext <= r[13:0];
    cf(32'h4);
    mi = (r[13:0] > 9999) ? 9999 : r[13:0];
    pulse(1'b0);
    cf(32'h0);
    wb(1'b1, 4'h4, 32'h3fff, q);
    mi = 9999;
    rc("interval", 4'h4, 32'hffffffff, 32'h270f);
    wb(1'b1, 4'h8, 32'h1869e, q);
    ot = 99998;
    cf(32'h8);
    tg = st(mi, ot);
    sw = 1'b0;
    mon(3);
    $display("test ext and limits done");
    conclude();
  end
endmodule : testbench
